// ===== logic/mrab_bridge.sv
// Operation
// - Normal memory: reorder allowed, speculative reads allowed
// - Device accesses keep order among Device/Strongly-ordered
// - Strongly-ordered keeps all order, writes never buffered
// - Strongly-ordered always shareable, coherent across masters
// - Block execute-never fetches; fault only on execution
// - Code region: Normal, write-through no allocate
// - SRAM region: Normal, write-back write allocate
// - Peripheral region: Device memory
// - External RAM: write-back low half, write-through high
// - External device: shareable low, non-shareable high
// - Core peripheral bus strongly-ordered; above it vendor Device
// - Protection unit overrides default region attributes
// - Bit-band lowest megabyte, each through own alias
// - Peripheral alias data remapped; instruction access refused
// - Alias write: atomic read-modify-write, one bit
// - Direct bit-band range accesses behave as ordinary accesses to their region
// - Alias transfers keep originating transfer size
// - Alias address: base plus 32*byte plus 4*bit
// - SRAM alias base hits first SRAM byte
// - Top SRAM alias word: last byte, bit 7
// - Instruction prefetch, including speculative branch targets
// - Data barrier and synchronization barrier wait for completion
// - Alias write uses only value bit 0
// - Alias read returns one or zero word
module mrab_bridge
(
  // Clock, reset, enable
  input  wire logic                    CLOCK,
  input  wire logic                    RST,
  input  wire logic                    CE,
  // Core request and response
  input  wire mrab_pkg::mrab_core_req_s CORE_REQ,
  output logic                         CORE_REQ_READY,
  output mrab_pkg::mrab_core_rsp_s     CORE_RSP,
  // Protection unit lookup for the presented request address
  input  wire mrab_pkg::mrab_prot_s    PROT,
  // Barriers
  input  wire mrab_pkg::mrab_bar_s     BAR_REQ,
  output logic                         BAR_READY,
  output logic                         BAR_DONE,
  output logic                         BAR_DONE_SYNC,
  // Execution of a blocked fetch
  input  wire logic                    EXEC_VALID,
  input  wire logic                    EXEC_BLOCKED,
  output logic                         EXEC_NEVER_FAULT,
  // System bus
  output mrab_pkg::mrab_bus_req_s      BUS_REQ,
  input  wire mrab_pkg::mrab_bus_rsp_s BUS_RSP
);
  import mrab_pkg::*;

  typedef enum logic [6:0]
  {
    ST_IDLE   = 7'b000_0001,
    ST_RD     = 7'b000_0010,
    ST_WR     = 7'b000_0100,
    ST_RMW_RD = 7'b000_1000,
    ST_RMW_WR = 7'b001_0000,
    ST_SPARE1 = 7'b010_0000,
    ST_SPARE2 = 7'b100_0000
  } mrab_st_e;

  typedef struct packed {
    mrab_st_e       st;
    logic           req_ready;
    logic           bar_ready;
    mrab_core_rsp_s rsp;
    mrab_bus_req_s  bus;
    logic           bar_done;
    logic           bar_done_sync;
    logic           bar_pend;
    logic           bar_pend_sync;
    logic           exec_fault;
    logic           bb;
    logic [4:0]     bb_pos;
    logic           bb_wval;
    logic           posted;
  } mrab_state_s;

  mrab_state_s s_r;
  mrab_state_s s_nxt;

  // Fixed address decode into type, shareability, cache policy
  function automatic mrab_attr_s decode(input logic [31:0] a);
    mrab_attr_s r;
    r = '{MRAB_MT_DEVICE, 1'b0, MRAB_CP_NONE, 1'b1};
    case (a[31:29])
      MRAB_RG_CODE:      r = '{MRAB_MT_NORMAL, 1'b0, MRAB_CP_WR_THRU, 1'b0};
      MRAB_RG_SRAM:      r = '{MRAB_MT_NORMAL, 1'b0, MRAB_CP_WR_BACK, 1'b0};
      MRAB_RG_PERIPH:    r = '{MRAB_MT_DEVICE, 1'b0, MRAB_CP_NONE, 1'b1};
      MRAB_RG_XRAM_BACK: r = '{MRAB_MT_NORMAL, 1'b0, MRAB_CP_WR_BACK, 1'b0};
      MRAB_RG_XRAM_THRU: r = '{MRAB_MT_NORMAL, 1'b0, MRAB_CP_WR_THRU, 1'b0};
      MRAB_RG_XDEV_SH: r = '{MRAB_MT_DEVICE, 1'b1, MRAB_CP_NONE, 1'b1};
      MRAB_RG_XDEV_NS: r = '{MRAB_MT_DEVICE, 1'b0, MRAB_CP_NONE, 1'b1};
      MRAB_RG_SYSTEM:
      begin
        if (a[31:20] == MRAB_PCPB_TAG)
          r = '{MRAB_MT_STRONG, 1'b1, MRAB_CP_NONE, 1'b1};
        else
          r = '{MRAB_MT_DEVICE, 1'b0, MRAB_CP_NONE, 1'b1};
      end
      default: r = '{MRAB_MT_DEVICE, 1'b0, MRAB_CP_NONE, 1'b1};
    endcase
    return r;
  endfunction

  // Align an address down to the transfer size
  function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
    logic [31:0] r;
    r = a;
    if (sz == MRAB_SZ_HALF)
      r = {a[31:1], 1'b0};
    else if (sz == MRAB_SZ_WORD)
      r = {a[31:2], 2'b00};
    return r;
  endfunction

  // Request decode, combinational on the presented request
  mrab_attr_s  attr;
  logic        is_alias;
  logic [31:0] bb_addr;
  logic [4:0]  bb_pos;
  logic        take_req;
  logic        take_bar;

  // Attribute selection and alias remap
  always_comb
  begin
    attr = decode(CORE_REQ.addr);
    if (PROT.hit)
      attr = PROT.attr;
    if (attr.mtype == MRAB_MT_STRONG)
      attr.shareable = 1'b1;
    is_alias = (CORE_REQ.addr[31:25] == MRAB_SRAM_ALIAS_TAG) ||
               (CORE_REQ.addr[31:25] == MRAB_PERIPH_ALIAS_TAG);
    // Region base keeps bits 31:29, byte offset from the alias word
    bb_addr = {CORE_REQ.addr[31:29], 9'h000,
               CORE_REQ.addr[MRAB_BB_OFS_HI:MRAB_BB_OFS_LO]};
    bb_pos = {bb_addr[1:0], CORE_REQ.addr[MRAB_BB_BIT_HI:MRAB_BB_BIT_LO]};
    take_req = CORE_REQ.valid && s_r.req_ready;
    take_bar = BAR_REQ.valid && s_r.bar_ready;
  end

  // Next state of the whole bridge
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp.valid = 1'b0;
    s_nxt.bar_done = 1'b0;
    s_nxt.bar_done_sync = 1'b0;
    s_nxt.exec_fault = EXEC_VALID && EXEC_BLOCKED;
    case (s_r.st)
      ST_IDLE:
      begin
        // Nothing is outstanding in idle, so a barrier completes at once
        if (take_bar)
        begin
          s_nxt.bar_done = 1'b1;
          s_nxt.bar_done_sync = BAR_REQ.sync;
        end
        if (take_req)
        begin
          s_nxt.rsp.rdata = MRAB_ALIAS_ZERO;
          s_nxt.rsp.err = 1'b0;
          s_nxt.rsp.blocked = 1'b0;
          s_nxt.bb = 1'b0;
          s_nxt.posted = 1'b0;
          s_nxt.bus.attr = attr;
          s_nxt.bus.size = CORE_REQ.size;
          s_nxt.bus.wdata = CORE_REQ.wdata;
          s_nxt.bus.lock = 1'b0;
          if (CORE_REQ.instr && (attr.execute_never || is_alias))
          begin
            // Fetch blocked without bus access; fault waits for execution
            s_nxt.rsp.valid = 1'b1;
            s_nxt.rsp.blocked = 1'b1;
          end
          else if (CORE_REQ.spec && (attr.mtype != MRAB_MT_NORMAL || is_alias))
          begin
            // Speculation only reaches Normal memory
            s_nxt.rsp.valid = 1'b1;
            s_nxt.rsp.err = 1'b1;
          end
          else
          begin
            s_nxt.bus.valid = 1'b1;
            s_nxt.req_ready = 1'b0;
            s_nxt.bar_ready = 1'b0;
            s_nxt.bus.addr = align(CORE_REQ.addr, CORE_REQ.size);
            s_nxt.bus.write = CORE_REQ.write && !is_alias;
            if (is_alias)
            begin
              s_nxt.bb = 1'b1;
              s_nxt.bb_pos = bb_pos;
              s_nxt.bb_wval = CORE_REQ.wdata[0];
              s_nxt.bus.addr = align(bb_addr, CORE_REQ.size);
              s_nxt.bus.attr = decode(bb_addr);
              if (PROT.hit)
                s_nxt.bus.attr = PROT.attr;
              if (s_nxt.bus.attr.mtype == MRAB_MT_STRONG)
                s_nxt.bus.attr.shareable = 1'b1;
              if (CORE_REQ.write)
              begin
                s_nxt.bus.lock = 1'b1;
                s_nxt.st = ST_RMW_RD;
              end
              else
                s_nxt.st = ST_RD;
            end
            else if (CORE_REQ.write)
            begin
              s_nxt.st = ST_WR;
              if (attr.mtype != MRAB_MT_STRONG)
              begin
                // Buffered write: answer now, barriers may queue behind it
                s_nxt.posted = 1'b1;
                s_nxt.rsp.valid = 1'b1;
                s_nxt.bar_ready = 1'b1;
              end
            end
            else
              s_nxt.st = ST_RD;
          end
        end
      end
      ST_RD:
      begin
        if (BUS_RSP.done)
        begin
          s_nxt.bus.valid = 1'b0;
          s_nxt.rsp.valid = 1'b1;
          s_nxt.rsp.err = BUS_RSP.err;
          if (s_r.bb)
            s_nxt.rsp.rdata = BUS_RSP.rdata[s_r.bb_pos] ? MRAB_ALIAS_ONE
                                                        : MRAB_ALIAS_ZERO;
          else
            s_nxt.rsp.rdata = BUS_RSP.rdata;
          s_nxt.st = ST_IDLE;
          s_nxt.req_ready = 1'b1;
          s_nxt.bar_ready = 1'b1;
        end
      end
      ST_WR:
      begin
        // A barrier taken behind a buffered write waits for its completion
        if (take_bar)
        begin
          s_nxt.bar_pend = 1'b1;
          s_nxt.bar_pend_sync = BAR_REQ.sync;
          s_nxt.bar_ready = 1'b0;
        end
        if (BUS_RSP.done)
        begin
          s_nxt.bus.valid = 1'b0;
          s_nxt.rsp.valid = !s_r.posted;
          s_nxt.rsp.err = BUS_RSP.err;
          s_nxt.bar_done = s_r.bar_pend || take_bar;
          s_nxt.bar_done_sync = s_r.bar_pend ? s_r.bar_pend_sync : BAR_REQ.sync;
          s_nxt.bar_pend = 1'b0;
          s_nxt.bar_pend_sync = 1'b0;
          s_nxt.st = ST_IDLE;
          s_nxt.req_ready = 1'b1;
          s_nxt.bar_ready = 1'b1;
        end
      end
      ST_RMW_RD:
      begin
        if (BUS_RSP.done)
        begin
          if (BUS_RSP.err)
          begin
            s_nxt.bus.valid = 1'b0;
            s_nxt.bus.lock = 1'b0;
            s_nxt.rsp.valid = 1'b1;
            s_nxt.rsp.err = 1'b1;
            s_nxt.st = ST_IDLE;
            s_nxt.req_ready = 1'b1;
            s_nxt.bar_ready = 1'b1;
          end
          else
          begin
            // Locked write back with only the target bit changed
            s_nxt.bus.write = 1'b1;
            s_nxt.bus.wdata = BUS_RSP.rdata;
            s_nxt.bus.wdata[s_r.bb_pos] = s_r.bb_wval;
            s_nxt.st = ST_RMW_WR;
          end
        end
      end
      ST_RMW_WR:
      begin
        if (BUS_RSP.done)
        begin
          s_nxt.bus.valid = 1'b0;
          s_nxt.bus.lock = 1'b0;
          s_nxt.rsp.valid = 1'b1;
          s_nxt.rsp.err = BUS_RSP.err;
          s_nxt.st = ST_IDLE;
          s_nxt.req_ready = 1'b1;
          s_nxt.bar_ready = 1'b1;
        end
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
        s_nxt.bus.valid = 1'b0;
        s_nxt.bus.lock = 1'b0;
        s_nxt.req_ready = 1'b1;
        s_nxt.bar_ready = 1'b1;
      end
    endcase
  end

  // State register, frozen while the enable is low
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.req_ready <= 1'b1;
      s_r.bar_ready <= 1'b1;
    end
    else if (CE)
      s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign CORE_REQ_READY = s_r.req_ready;
  assign CORE_RSP       = s_r.rsp;
  assign BAR_READY      = s_r.bar_ready;
  assign BAR_DONE       = s_r.bar_done;
  assign BAR_DONE_SYNC  = s_r.bar_done_sync;
  assign EXEC_NEVER_FAULT = s_r.exec_fault;
  assign BUS_REQ        = s_r.bus;

endmodule

// ===== logic/mrab_pkg.sv
package mrab_pkg;

  // Memory type, cache policy and transfer size encodings
  localparam logic [1:0] MRAB_MT_NORMAL = 2'h0;
  localparam logic [1:0] MRAB_MT_DEVICE = 2'h1;
  localparam logic [1:0] MRAB_MT_STRONG = 2'h2;
  localparam logic [1:0] MRAB_CP_NONE   = 2'h0;
  localparam logic [1:0] MRAB_CP_WR_THRU = 2'h1;
  localparam logic [1:0] MRAB_CP_WR_BACK = 2'h2;
  localparam logic [1:0] MRAB_SZ_BYTE   = 2'h0;
  localparam logic [1:0] MRAB_SZ_HALF   = 2'h1;
  localparam logic [1:0] MRAB_SZ_WORD   = 2'h2;

  // Fixed map: region code is address bits 31:29
  localparam logic [2:0] MRAB_RG_CODE    = 3'h0;
  localparam logic [2:0] MRAB_RG_SRAM    = 3'h1;
  localparam logic [2:0] MRAB_RG_PERIPH  = 3'h2;
  localparam logic [2:0] MRAB_RG_XRAM_BACK = 3'h3;
  localparam logic [2:0] MRAB_RG_XRAM_THRU = 3'h4;
  localparam logic [2:0] MRAB_RG_XDEV_SH = 3'h5;
  localparam logic [2:0] MRAB_RG_XDEV_NS = 3'h6;
  localparam logic [2:0] MRAB_RG_SYSTEM  = 3'h7;
  // Private core-peripheral bus: address bits 31:20 equal to this
  localparam logic [11:0] MRAB_PCPB_TAG  = 12'hE00;

  // Alias regions: address bits 31:25 (0x22000000 and 0x42000000)
  localparam logic [6:0] MRAB_SRAM_ALIAS_TAG   = 7'h11;
  localparam logic [6:0] MRAB_PERIPH_ALIAS_TAG = 7'h21;
  // Bit-band byte offset is alias bits 24:5, bit number bits 4:2
  localparam int MRAB_BB_OFS_HI = 24;
  localparam int MRAB_BB_OFS_LO = 5;
  localparam int MRAB_BB_BIT_HI = 4;
  localparam int MRAB_BB_BIT_LO = 2;

  localparam logic [31:0] MRAB_ALIAS_ONE  = 32'h0000_0001;
  localparam logic [31:0] MRAB_ALIAS_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] mtype;
    logic       shareable;
    logic [1:0] cache;
    logic       execute_never;
  } mrab_attr_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        instr;
    logic        spec;
  } mrab_core_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
    logic        err;
    logic        blocked;
  } mrab_core_rsp_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        lock;
    mrab_attr_s  attr;
  } mrab_bus_req_s;

  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
    logic        err;
  } mrab_bus_rsp_s;

  typedef struct packed {
    logic       hit;
    mrab_attr_s attr;
  } mrab_prot_s;

  typedef struct packed {
    logic valid;
    logic sync;
  } mrab_bar_s;

endpackage

// ===== tb/mrab_chk.sv
module mrab_chk
  import mrab_pkg::*;
(
  // Clock, reset and enable
  input wire logic                     CLOCK,
  input wire logic                     RST,
  input wire logic                     CE,
  // Core side
  input wire mrab_pkg::mrab_core_req_s CORE_REQ,
  input wire logic                     CORE_REQ_READY,
  input wire mrab_pkg::mrab_core_rsp_s CORE_RSP,
  input wire mrab_pkg::mrab_prot_s     PROT,
  // Barriers and execution
  input wire mrab_pkg::mrab_bar_s      BAR_REQ,
  input wire logic                     BAR_READY,
  input wire logic                     BAR_DONE,
  input wire logic                     BAR_DONE_SYNC,
  input wire logic                     EXEC_VALID,
  input wire logic                     EXEC_BLOCKED,
  input wire logic                     EXEC_NEVER_FAULT,
  // System bus
  input wire mrab_pkg::mrab_bus_req_s  BUS_REQ,
  input wire mrab_pkg::mrab_bus_rsp_s  BUS_RSP
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic        tk;
  logic        hit_r;
  mrab_attr_s  pa_r;
  logic [31:0] ta_r;
  logic [1:0]  ts_r;
  logic [31:0] bb;
  assign tk = CE && CORE_REQ.valid && CORE_REQ_READY;
  // Bit-band byte of the last request, aligned to its size
  always_comb
  begin
    bb = {ta_r[31:29], 9'h000, ta_r[24:5]};
    if (ts_r == MRAB_SZ_WORD)
      bb[1:0] = 2'h0;
    if (ts_r == MRAB_SZ_HALF)
      bb[0] = 1'h0;
  end
  // Last taken request and its lookup
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      hit_r <= 1'h0;
      pa_r  <= '0;
      ta_r  <= '0;
      ts_r  <= '0;
    end
    else if (tk)
    begin
      hit_r <= PROT.hit;
      pa_r  <= PROT.attr;
      ta_r  <= CORE_REQ.addr;
      ts_r  <= CORE_REQ.size;
    end
  end
  AST_BUS_HOLD: assert property (BUS_REQ.valid && !BUS_RSP.done |=>
    BUS_REQ.valid && $stable(BUS_REQ.addr)) else $error("Bus request dropped early");
  AST_SO_SHARE: assert property (BUS_REQ.valid && BUS_REQ.attr.mtype == MRAB_MT_STRONG
    |-> BUS_REQ.attr.shareable) else $error("Strong region not shareable");
  AST_CODE_MAP: assert property ($rose(BUS_REQ.valid) && !hit_r
    && BUS_REQ.addr[31:29] == MRAB_RG_CODE |-> BUS_REQ.attr.mtype == MRAB_MT_NORMAL
    && BUS_REQ.attr.cache == MRAB_CP_WR_THRU) else $error("Code region attributes wrong");
  AST_PERI_MAP: assert property ($rose(BUS_REQ.valid) && !hit_r
    && BUS_REQ.addr[31:29] == MRAB_RG_PERIPH |-> BUS_REQ.attr.mtype == MRAB_MT_DEVICE)
    else $error("Peripheral region not device");
  AST_PROT_OVR: assert property ($rose(BUS_REQ.valid) && hit_r
    && pa_r.mtype != MRAB_MT_STRONG |-> BUS_REQ.attr == pa_r) else $error("Lookup ignored");
  AST_ALIAS_ADR: assert property ($rose(BUS_REQ.lock) |-> BUS_REQ.addr == bb
    && BUS_REQ.size == ts_r) else $error("Alias target wrong");
  AST_RMW: assert property (BUS_REQ.valid && BUS_REQ.lock && !BUS_REQ.write
    && BUS_RSP.done && !BUS_RSP.err |=> BUS_REQ.valid && BUS_REQ.write && BUS_REQ.lock
    && $stable(BUS_REQ.addr)) else $error("Locked write missing");
  AST_ALIAS_FETCH: assert property (tk && CORE_REQ.instr
    && CORE_REQ.addr[31:25] == MRAB_PERIPH_ALIAS_TAG |=> CORE_RSP.valid && CORE_RSP.blocked
    && !BUS_REQ.valid) else $error("Alias fetch not refused");
  AST_EXEC_FAULT: assert property (CE && EXEC_VALID && EXEC_BLOCKED
    |=> EXEC_NEVER_FAULT) else $error("Fault missing");
  AST_BAR_IDLE: assert property (CE && BAR_REQ.valid && BAR_READY && !BUS_REQ.valid
    |=> BAR_DONE && BAR_DONE_SYNC == $past(BAR_REQ.sync)) else $error("Barrier late");
  AST_BAR_WAIT: assert property (BAR_DONE
    |-> !$past(BUS_REQ.valid) || $past(BUS_RSP.done)) else $error("Barrier before completion");
  // Main scenarios
  COV_RMW: cover property (BUS_REQ.valid && BUS_REQ.lock && BUS_REQ.write);
  COV_BAR: cover property (BAR_DONE && BAR_DONE_SYNC);
  COV_BLK: cover property (CORE_RSP.valid && CORE_RSP.blocked);
endmodule

bind mrab_bridge mrab_chk i_mrab_chk (.CLOCK, .RST, .CE, .CORE_REQ, .CORE_REQ_READY,
  .CORE_RSP, .PROT, .BAR_REQ, .BAR_READY, .BAR_DONE, .BAR_DONE_SYNC, .EXEC_VALID,
  .EXEC_BLOCKED, .EXEC_NEVER_FAULT, .BUS_REQ, .BUS_RSP);

// ===== tb/mrab_mem.sv
module mrab_mem
  import mrab_pkg::*;
(
  // Clock and reset
  input wire logic                     CLOCK,
  input wire logic                     RST,
  // System bus
  input wire mrab_pkg::mrab_bus_req_s  BUS_REQ,
  output mrab_pkg::mrab_bus_rsp_s      BUS_RSP
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [29:0]];
  logic [31:0] cur;
  logic [31:0] msk;
  logic [1:0]  dly;
  logic [1:0]  cnt;
  // Slave with a wait of 0 to 3 cycles that varies per transfer
  always @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      BUS_RSP <= '0;
      cnt     <= 2'h0;
      dly     <= 2'h0;
    end
    else if (BUS_RSP.done)
    begin
      BUS_RSP.done  <= 1'h0;
      BUS_RSP.rdata <= ~BUS_RSP.rdata; // Released lines show no stale data
    end
    else if (BUS_REQ.valid && cnt != 2'h0)
      cnt <= cnt - 2'h1;
    else if (BUS_REQ.valid)
    begin
      cur = mem.exists(BUS_REQ.addr[31:2]) ? mem[BUS_REQ.addr[31:2]] : ~BUS_REQ.addr;
      msk = BUS_REQ.size == MRAB_SZ_WORD ? 32'hffff_ffff
          : BUS_REQ.size == MRAB_SZ_HALF ? 32'h0000_ffff << {BUS_REQ.addr[1], 4'h0}
          : 32'h0000_00ff << {BUS_REQ.addr[1:0], 3'h0};
      if (BUS_REQ.write)
        mem[BUS_REQ.addr[31:2]] = (cur & ~msk) | (BUS_REQ.wdata & msk);
      BUS_RSP <= {1'h1, cur, 1'h0};
      dly     <= dly + 2'h1;
      cnt     <= dly;
    end
  end
endmodule

// ===== tb/mrab_bridge_tb.sv
module mrab_bridge_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mrab_pkg::*;
  logic           clock;
  logic           rst;
  logic           ce;
  mrab_core_req_s creq;
  mrab_prot_s     prot;
  mrab_bar_s      bar;
  logic           ev;
  logic           eb;
  logic           rdy;
  mrab_core_rsp_s crsp;
  logic           brdy;
  logic           bdone;
  logic           bsync;
  logic           xnf;
  mrab_bus_req_s  breq;
  mrab_bus_rsp_s  brsp;
  mrab_bus_req_s  bq;
  mrab_core_rsp_s r;
  logic [31:0]    seed;
  int             bad_count;
  int             checks;
  logic [31:0]    cor [10] = '{32'h1fff_fffc, 32'h2000_0000, 32'h400f_fffc, 32'h5fff_fffc,
    32'h6000_0000, 32'h9fff_fffc, 32'ha000_0000, 32'hdfff_fffc, 32'he00f_fffc, 32'he010_0000};
  // Design and bus slave
  mrab_bridge i_mrab_bridge (.CLOCK(clock), .RST(rst), .CE(ce), .CORE_REQ(creq),
    .CORE_REQ_READY(rdy), .CORE_RSP(crsp), .PROT(prot), .BAR_REQ(bar), .BAR_READY(brdy),
    .BAR_DONE(bdone), .BAR_DONE_SYNC(bsync), .EXEC_VALID(ev), .EXEC_BLOCKED(eb),
    .EXEC_NEVER_FAULT(xnf), .BUS_REQ(breq), .BUS_RSP(brsp));
  mrab_mem i_mrab_mem (.CLOCK(clock), .RST(rst), .BUS_REQ(breq), .BUS_RSP(brsp));
  // Clock and last bus beat seen
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
    if (breq.valid)
      bq <= breq;
  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Default attributes of the fixed map
  function automatic mrab_attr_s ea(input logic [31:0] a);
    case (a[31:29])
      MRAB_RG_CODE:      ea = {MRAB_MT_NORMAL, 1'h0, MRAB_CP_WR_THRU, 1'h0};
      MRAB_RG_SRAM:      ea = {MRAB_MT_NORMAL, 1'h0, MRAB_CP_WR_BACK, 1'h0};
      MRAB_RG_XRAM_BACK: ea = {MRAB_MT_NORMAL, 1'h0, MRAB_CP_WR_BACK, 1'h0};
      MRAB_RG_XRAM_THRU: ea = {MRAB_MT_NORMAL, 1'h0, MRAB_CP_WR_THRU, 1'h0};
      MRAB_RG_XDEV_SH: ea = {MRAB_MT_DEVICE, 1'h1, MRAB_CP_NONE, 1'h1};
      MRAB_RG_SYSTEM:  ea = a[31:20] == MRAB_PCPB_TAG ? {MRAB_MT_STRONG, 1'h1, MRAB_CP_NONE, 1'h1}
                          : {MRAB_MT_DEVICE, 1'h0, MRAB_CP_NONE, 1'h1};
      default:         ea = {MRAB_MT_DEVICE, 1'h0, MRAB_CP_NONE, 1'h1};
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      $display("Error %0t: %s got %h expected %h", $time, m, g, e);
      bad_count++;
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo;
    $display("Error %0t: wait ran out", $time);
    bad_count++;
    report_and_stop;
  endtask
  // One core transfer: hold until taken, then wait for the answer
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s,
    input logic [31:0] d, input logic i, input logic p, input mrab_prot_s pp);
    int n;
    @(posedge clock);
    creq <= {1'h1, a, w, s, d, i, p};
    prot <= pp;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (rdy !== 1'h1 && n < 60);
    if (rdy !== 1'h1)
      tmo;
    @(posedge clock);
    creq.valid <= 1'h0;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (crsp.valid !== 1'h1 && n < 60);
    if (crsp.valid !== 1'h1)
      tmo;
    r = crsp;
  endtask
  // One barrier, held until taken, then its completion
  task automatic brq(input logic s);
    int n;
    @(posedge clock);
    bar <= {1'h1, s};
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (brdy !== 1'h1 && n < 60);
    @(posedge clock);
    bar.valid <= 1'h0;
    do
    begin
      @(negedge clock);
      n++;
    end while (bdone !== 1'h1 && n < 120);
    if (bdone !== 1'h1)
      tmo;
    chk(bsync, s, "barrier kind");
  endtask
  initial
  begin
    logic [31:0] a;
    logic [31:0] w;
    logic [31:0] e;
    mrab_attr_s  x;
    logic [19:0] o;
    logic [2:0]  k;
    logic [1:0]  s;
    logic        v;
    rst = 1'h1;
    ce = 1'h1;
    creq = '0;
    prot = '0;
    bar = '0;
    ev = 1'h0;
    eb = 1'h0;
    seed = 32'h2167_ea7d;
    bad_count = 0;
    checks = 0;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    // Fixed decode over corner and random addresses
    for (int i = 0; i < 30; i++)
    begin
      seed = nx(seed);
      a = i < 10 ? cor[i] : {seed[31:2], 2'h0};
      if (a[31:25] == MRAB_SRAM_ALIAS_TAG || a[31:25] == MRAB_PERIPH_ALIAS_TAG)
        a[25] = 1'h0;
      acc(a, 1'h0, MRAB_SZ_WORD, 32'h0000_0000, 1'h0, 1'h0, '0);
      x = ea(a);
      chk(bq.addr, a, "direct address");
      chk(bq.attr.mtype, x.mtype, "type");
      chk(bq.attr.cache, x.cache, "cache policy");
      if (a[31:29] inside {3'h5, 3'h6} || a[31:20] == MRAB_PCPB_TAG)
        chk(bq.attr.shareable, x.shareable, "shareability");
    end
    // Lookup overrides the map; strong stays shareable
    acc(32'h2000_0100, 1'h0, MRAB_SZ_WORD, 32'h0, 1'h0, 1'h0, 7'h5a);
    chk(bq.attr, 6'h1a, "override");
    acc(32'h2000_0100, 1'h0, MRAB_SZ_WORD, 32'h0, 1'h0, 1'h0, 7'h60);
    chk(bq.attr.shareable, 1'h1, "strong shared");
    // Strong write waits; device write then barriers
    acc(32'he000_0010, 1'h1, MRAB_SZ_WORD, seed, 1'h0, 1'h0, '0);
    chk(breq.valid, 1'h0, "strong write done");
    acc(32'h4000_0010, 1'h1, MRAB_SZ_WORD, seed, 1'h0, 1'h0, '0);
    brq(1'h1);
    brq(1'h0);
    // Bit-band alias write and read, corners first
    for (int i = 0; i < 14; i++)
    begin
      seed = nx(seed);
      o = i == 0 ? 20'h0_0000 : i == 1 ? 20'hf_ffff : seed[19:0];
      k = i == 0 ? 3'h0 : i == 1 ? 3'h7 : seed[22:20];
      s = seed[24:23] == 2'h3 ? MRAB_SZ_WORD : seed[24:23];
      a = {(i < 2 || seed[25]) ? 3'h1 : 3'h2, 9'h000, o};
      v = seed[26];
      w = nx(seed);
      acc({a[31:2], 2'h0}, 1'h1, MRAB_SZ_WORD, w, 1'h0, 1'h0, '0);
      acc({a[31:29], 4'h1, o, k, 2'h0}, 1'h1, s, {seed[31:1], v}, 1'h0, 1'h0, '0);
      e = s == MRAB_SZ_WORD ? {a[31:2], 2'h0} : s == MRAB_SZ_HALF ? {a[31:1], 1'h0} : a;
      chk(bq.addr, e, "alias target");
      chk(bq.size, s, "alias size");
      w[{a[1:0], k}] = v;
      acc({a[31:29], 4'h1, o, k, 2'h0}, 1'h0, s, 32'h0, 1'h0, 1'h0, '0);
      chk(r.rdata, {31'h0, v}, "alias read");
      acc({a[31:2], 2'h0}, 1'h0, MRAB_SZ_WORD, 32'h0, 1'h0, 1'h0, '0);
      chk(r.rdata, w, "one bit changed");
    end
    // Refused fetches with no fault, accepted code prefetch, refused speculation
    acc(32'h4000_0000, 1'h0, MRAB_SZ_WORD, 32'h0, 1'h1, 1'h0, '0);
    chk(r.blocked, 1'h1, "never-execute fetch");
    chk(xnf, 1'h0, "no fault on fetch");
    acc(32'h4200_0000, 1'h0, MRAB_SZ_WORD, 32'h0, 1'h1, 1'h0, '0);
    chk(r.blocked, 1'h1, "alias fetch");
    acc(32'h0000_0100, 1'h0, MRAB_SZ_WORD, 32'h0, 1'h1, 1'h1, '0);
    chk({r.blocked, r.err}, 2'h0, "code prefetch");
    acc(32'h4000_0000, 1'h0, MRAB_SZ_WORD, 32'h0, 1'h0, 1'h1, '0);
    chk(r.err, 1'h1, "speculative device");
    // Execution seen with the enable low is ignored, then faults once running
    @(posedge clock);
    ev <= 1'h1;
    eb <= 1'h1;
    ce <= 1'h0;
    @(posedge clock);
    ce <= 1'h1;
    @(negedge clock);
    chk(xnf, 1'h0, "fault while frozen");
    @(posedge clock);
    ev <= 1'h0;
    eb <= 1'h0;
    @(negedge clock);
    chk(xnf, 1'h1, "execution fault");
    report_and_stop;
  end
endmodule
